// file: rtl/cog_pkg.sv
// constants for the channel offset and gain register bank
// assumes a 16-bit data word and a 4-bit register address on the serial link
`default_nettype none

package cog_pkg;

	////////////////////////////////////////////////////////////////////////////
	// serial frame: address first, then data, both msb first
	localparam int unsigned FRAME_ADDR_BITS = 4;
	localparam int unsigned FRAME_DATA_BITS = 16;
	localparam int unsigned FRAME_BITS      = FRAME_ADDR_BITS + FRAME_DATA_BITS;
	localparam int unsigned FRAME_CNT_W     = 5;

	////////////////////////////////////////////////////////////////////////////
	// register addresses
	localparam logic [3:0] ADDR_I_OFFSET    = 4'h2;
	localparam logic [3:0] ADDR_I_FULLSCALE = 4'h3;
	localparam logic [3:0] ADDR_Q_OFFSET    = 4'hA;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned OFS_MAG_MSB  = 15;
	localparam int unsigned OFS_MAG_LSB  = 8;
	localparam int unsigned OFS_SIGN_BIT = 7;
	localparam int unsigned FS_GAIN_MSB  = 15;
	localparam int unsigned FS_GAIN_LSB  = 7;
	localparam int unsigned FILL_MSB     = 6;
	localparam int unsigned FILL_LSB     = 0;

	////////////////////////////////////////////////////////////////////////////
	// reset images and field values
	localparam logic [15:0] RST_I_OFFSET    = 16'h007F;
	localparam logic [15:0] RST_I_FULLSCALE = 16'h807F;
	localparam logic [15:0] RST_Q_OFFSET    = 16'h007F;
	localparam logic [7:0]  OFS_MAG_ZERO    = 8'h00;
	localparam logic        SIGN_POSITIVE   = 1'b0;
	localparam logic        SIGN_NEGATIVE   = 1'b1;
	localparam logic [8:0]  GAIN_MIN        = 9'h000;
	localparam logic [8:0]  GAIN_NOMINAL    = 9'h100;
	localparam logic [8:0]  GAIN_MAX        = 9'h1FF;
	localparam logic [6:0]  FILL_ONES       = 7'h7F;

	////////////////////////////////////////////////////////////////////////////
	// analog scale of the codes, in microvolts
	localparam int unsigned OFS_STEP_UV    = 176;
	localparam int unsigned FS_MIN_UV      = 560000;
	localparam int unsigned FS_NOMINAL_UV  = 700000;
	localparam int unsigned FS_MAX_UV      = 840000;

endpackage : cog_pkg

`default_nettype wire

// file: rtl/cog_regs.sv
// offset and full-scale control registers of a dual-channel converter
// assumes the serial pins are synchronous to clock and ext_mode is a steady level
//
// Summary of operation
// - I offset magnitude lives in bits 15:8.
// - magnitude zero is no offset, steps add.
// - bit 7 is offset sign, resets positive.
// - I gain code bits 15:7, resets mid-scale.
// - Q offset uses the I offset layout.
// - settings act only in extended control mode.
`default_nettype none

module cog_regs (
	// system
	input  wire logic        clock,
	input  wire logic        resetn,
	// serial control pins
	input  wire logic        sclk,
	input  wire logic        sdata,
	input  wire logic        scs_n,
	// control mode select, high for extended control
	input  wire logic        ext_mode,
	// effective I channel settings
	output logic [7:0]       i_offset_mag,
	output logic             i_offset_neg,
	output logic [8:0]       i_gain_code,
	// effective Q channel settings
	output logic [7:0]       q_offset_mag,
	output logic             q_offset_neg,
	// status
	output logic             filler_error
);

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic        wr_valid;
	logic [3:0]  wr_addr;
	logic [15:0] wr_data;
	logic [15:0] i_offset_q;
	logic [15:0] i_fullscale_q;
	logic [15:0] q_offset_q;
	logic [7:0]  i_mag_q;
	logic        i_neg_q;
	logic [8:0]  i_gain_q;
	logic [7:0]  q_mag_q;
	logic        q_neg_q;
	logic        fill_err_q;
	logic        hit_i_ofs;
	logic        hit_i_fs;
	logic        hit_q_ofs;
	logic        fill_bad;

	////////////////////////////////////////////////////////////////////////////
	// serial receiver
	cog_serial_rx u_rx (
		.clock    (clock),
		.resetn   (resetn),
		.sclk     (sclk),
		.sdata    (sdata),
		.scs_n    (scs_n),
		.wr_valid (wr_valid),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// address decode; other addresses are dropped silently
	assign hit_i_ofs = wr_valid && wr_addr == cog_pkg::ADDR_I_OFFSET;
	assign hit_i_fs  = wr_valid && wr_addr == cog_pkg::ADDR_I_FULLSCALE;
	assign hit_q_ofs = wr_valid && wr_addr == cog_pkg::ADDR_Q_OFFSET;

	// filler bits not all ones on a write to one of our registers
	assign fill_bad = (hit_i_ofs || hit_i_fs || hit_q_ofs)
	                  && wr_data[cog_pkg::FILL_MSB:cog_pkg::FILL_LSB] != cog_pkg::FILL_ONES;

	////////////////////////////////////////////////////////////////////////////
	// I offset register: magnitude high byte, sign in bit 7
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			i_offset_q <= cog_pkg::RST_I_OFFSET;
		end else if (hit_i_ofs) begin
			i_offset_q <= wr_data;
		end
	end

	// I full-scale register; gain changes take effect without recalibration
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			i_fullscale_q <= cog_pkg::RST_I_FULLSCALE;
		end else if (hit_i_fs) begin
			i_fullscale_q <= wr_data;
		end
	end

	// Q offset register, same layout as the I one
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			q_offset_q <= cog_pkg::RST_Q_OFFSET;
		end else if (hit_q_ofs) begin
			q_offset_q <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// effective settings: in normal mode the analog side sees the nominal
	// codes, so stored values wait untouched for a later switch to extended
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			i_mag_q  <= cog_pkg::OFS_MAG_ZERO;
			i_neg_q  <= cog_pkg::SIGN_POSITIVE;
			i_gain_q <= cog_pkg::GAIN_NOMINAL;
			q_mag_q  <= cog_pkg::OFS_MAG_ZERO;
			q_neg_q  <= cog_pkg::SIGN_POSITIVE;
		end else if (ext_mode) begin
			i_mag_q  <= i_offset_q[cog_pkg::OFS_MAG_MSB:cog_pkg::OFS_MAG_LSB];
			i_neg_q  <= i_offset_q[cog_pkg::OFS_SIGN_BIT];
			i_gain_q <= i_fullscale_q[cog_pkg::FS_GAIN_MSB:cog_pkg::FS_GAIN_LSB];
			q_mag_q  <= q_offset_q[cog_pkg::OFS_MAG_MSB:cog_pkg::OFS_MAG_LSB];
			q_neg_q  <= q_offset_q[cog_pkg::OFS_SIGN_BIT];
		end else begin
			i_mag_q  <= cog_pkg::OFS_MAG_ZERO;
			i_neg_q  <= cog_pkg::SIGN_POSITIVE;
			i_gain_q <= cog_pkg::GAIN_NOMINAL;
			q_mag_q  <= cog_pkg::OFS_MAG_ZERO;
			q_neg_q  <= cog_pkg::SIGN_POSITIVE;
		end
	end

	// magnitude code zero means zero offset; each step is one offset lsb
	assign i_offset_mag = i_mag_q;
	assign i_offset_neg = i_neg_q;
	assign i_gain_code  = i_gain_q;
	assign q_offset_mag = q_mag_q;
	assign q_offset_neg = q_neg_q;

	////////////////////////////////////////////////////////////////////////////
	// sticky flag for a host that broke the filler convention; the data are
	// still stored since the filler bits steer nothing; cleared only by reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fill_err_q <= 1'b0;
		end else if (fill_bad) begin
			fill_err_q <= 1'b1;
		end
	end

	assign filler_error = fill_err_q;

endmodule : cog_regs

`default_nettype wire

// file: rtl/cog_serial_rx.sv
// serial write receiver for the extended control link
// assumes sclk, sdata and scs_n are already synchronous to clock
`default_nettype none

module cog_serial_rx (
	// system
	input  wire logic        clock,
	input  wire logic        resetn,
	// serial pins
	input  wire logic        sclk,
	input  wire logic        sdata,
	input  wire logic        scs_n,
	// decoded write
	output logic             wr_valid,
	output logic [3:0]       wr_addr,
	output logic [15:0]      wr_data
);

	////////////////////////////////////////////////////////////////////////////
	logic                                  sclk_q;
	logic [cog_pkg::FRAME_BITS-1:0]        shift_q;
	logic [cog_pkg::FRAME_CNT_W-1:0]       count_q;
	logic                                  valid_q;
	logic [3:0]                            addr_q;
	logic [15:0]                           data_q;
	logic                                  rise;

	// sampling on the rising sclk edge as seen by the system clock
	assign rise = sclk & ~sclk_q;

	// previous sclk level for the edge detect
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
		end
	end

	// shift and count; bits past a full frame are ignored until select rises
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shift_q <= '0;
			count_q <= '0;
		end else if (scs_n) begin
			count_q <= '0;
		end else if (rise && count_q < cog_pkg::FRAME_CNT_W'(cog_pkg::FRAME_BITS)) begin
			shift_q <= {shift_q[cog_pkg::FRAME_BITS-2:0], sdata};
			count_q <= count_q + 5'h01;
		end
	end

	// one-cycle write pulse when the last frame bit lands
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			valid_q <= 1'b0;
			addr_q  <= 4'h0;
			data_q  <= 16'h0000;
		end else begin
			valid_q <= 1'b0;
			if (!scs_n && rise
			    && count_q == cog_pkg::FRAME_CNT_W'(cog_pkg::FRAME_BITS - 1)) begin
				valid_q <= 1'b1;
				addr_q  <= shift_q[cog_pkg::FRAME_BITS-2:cog_pkg::FRAME_DATA_BITS-1];
				data_q  <= {shift_q[cog_pkg::FRAME_DATA_BITS-2:0], sdata};
			end
		end
	end

	assign wr_valid = valid_q;
	assign wr_addr  = addr_q;
	assign wr_data  = data_q;

endmodule : cog_serial_rx

`default_nettype wire

// file: sim/cog_host.sv
// host model that writes frames on the serial control pins
// assumes the bench calls send only between frames
`default_nettype none
module cog_host (
	// system
	input  wire logic clock,
	// serial pins
	output var logic  sclk,
	output var logic  sdata,
	output var logic  scs_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle pins: clock parked low so reset release sees no false edge
	initial begin
		sclk = 1'b0;
		sdata = 1'b0;
		scs_n = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////
	// address then data, msb first; each half bit lasts one clock
	task automatic send(input logic [3:0] a, input logic [15:0] d);
		logic [19:0] f;
		f = {a, d};
		@(negedge clock) scs_n = 1'b0;
		for (int i = 19; i >= 0; i--) begin
			@(negedge clock) sclk = 1'b0;
			sdata = f[i];
			@(negedge clock) sclk = 1'b1;
		end
		@(negedge clock) sclk = 1'b0;
		scs_n = 1'b1;
		sdata = ~sdata; // released line must not show the last bit
	endtask : send
endmodule : cog_host
`default_nettype wire

// file: sim/cog_regs_sva.sv
// assertions on the ports of the offset and gain register bank
// assumes outputs lag a frame by three clocks and ext_mode by one
`default_nettype none
module cog_regs_sva (
	// system and serial pins
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic       sclk,
	input wire logic       sdata,
	input wire logic       scs_n,
	input wire logic       ext_mode,
	// effective settings
	input wire logic [7:0] i_offset_mag,
	input wire logic       i_offset_neg,
	input wire logic [8:0] i_gain_code,
	input wire logic [7:0] q_offset_mag,
	input wire logic       q_offset_neg,
	input wire logic       filler_error
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// reset images read as no offset and mid-scale gain
	a_reset_ofs: assert property ($rose(resetn) |->
		{i_offset_mag, i_offset_neg, q_offset_mag, q_offset_neg} == 18'h0)
		else $error("offsets not cleared by reset");
	a_reset_gain: assert property ($rose(resetn) |-> i_gain_code == 9'h100)
		else $error("gain not mid-scale after reset");
	// normal mode hides the stored settings
	a_normal_ofs: assert property (!ext_mode && !$past(ext_mode) && !$past(ext_mode, 2)
		|-> {i_offset_mag, i_offset_neg, q_offset_mag, q_offset_neg} == 18'h0)
		else $error("offset active in normal mode");
	a_normal_gain: assert property (!ext_mode && !$past(ext_mode)
		&& !$past(ext_mode, 2) |-> i_gain_code == 9'h100)
		else $error("gain active in normal mode");
	// no frame can finish while the select stayed high
	a_hold_ofs: assert property (ext_mode && $past(ext_mode) && $past(ext_mode, 2)
		&& scs_n && $past(scs_n, 4)
		|-> $stable({i_offset_mag, i_offset_neg, q_offset_mag, q_offset_neg}))
		else $error("offset moved without a frame");
	a_hold_gain: assert property (ext_mode && $past(ext_mode) && $past(ext_mode, 2)
		&& scs_n && $past(scs_n, 4) |-> $stable(i_gain_code))
		else $error("gain moved without a frame");
	c_ofs_write: cover property (ext_mode && $changed(i_offset_mag));
	c_mode_drop: cover property ($fell(ext_mode));
	c_filler: cover property ($rose(filler_error));
endmodule : cog_regs_sva
bind cog_regs cog_regs_sva u_sva (.clock, .resetn, .sclk, .sdata, .scs_n, .ext_mode,
	.i_offset_mag, .i_offset_neg, .i_gain_code, .q_offset_mag, .q_offset_neg,
	.filler_error);
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the offset and gain register bank
// assumes cog_host drives the serial pins and the checker is bound in
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock = 1'b0;
	logic       resetn = 1'b0;
	logic       ext_mode = 1'b1;
	logic       sclk, sdata, scs_n, i_neg, q_neg, ferr;
	logic [7:0] i_mag, q_mag;
	logic [8:0] gain;
	logic [8:0] g [3] = '{9'h000, 9'h1FF, 9'h0C0};
	int         bad_count = 0;
	int         comparisons = 0;
	int         cycles = 0;
	wire logic [27:0] st = {i_mag, i_neg, gain, q_mag, q_neg, ferr};
	// free-running 250 MHz system clock
	always #2 clock = ~clock;
	cog_host u_host (.clock, .sclk, .sdata, .scs_n);
	cog_regs u_cog_regs (.clock, .resetn, .sclk, .sdata, .scs_n, .ext_mode,
		.i_offset_mag(i_mag), .i_offset_neg(i_neg), .i_gain_code(gain),
		.q_offset_mag(q_mag), .q_offset_neg(q_neg), .filler_error(ferr));
	////////////////////////////////////////////////////////////////////////////
	// case equality so an unknown on any output counts as a mismatch
	task automatic chk(string n, logic [27:0] s, logic [27:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one frame, then let the three-clock write latency pass
	task automatic wr(logic [3:0] a, logic [15:0] d);
		u_host.send(a, d);
		repeat (4) @(negedge clock);
	endtask : wr
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	// a hang counts as a mismatch
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// scenarios: reset images, writes, mode switch, then a second reset
	initial begin
		repeat (5) @(negedge clock);
		resetn = 1'b1;
		@(negedge clock);
		chk("reset", st, {8'h00, 1'b0, 9'h100, 8'h00, 2'b00});
		wr(4'h2, 16'hA5FF);
		chk("i_ofs", st, {8'hA5, 1'b1, 9'h100, 8'h00, 2'b00});
		wr(4'hA, 16'h3C7F);
		chk("q_ofs", st, {8'hA5, 1'b1, 9'h100, 8'h3C, 2'b00});
		$display("test offsets done");
		// gain extremes, then a code inside the recommended span
		foreach (g[i]) begin
			wr(4'h3, {g[i], 7'h7F});
			chk("gain", st, {8'hA5, 1'b1, g[i], 8'h3C, 2'b00});
		end
		wr(4'h5, 16'h00FF);
		chk("unmapped", st, {8'hA5, 1'b1, 9'h0C0, 8'h3C, 2'b00});
		wr(4'hA, 16'hFFFF);
		chk("q_max", st, {8'hA5, 1'b1, 9'h0C0, 8'hFF, 2'b10});
		$display("test gain done");
		ext_mode = 1'b0;
		repeat (3) @(negedge clock);
		chk("normal", st, {8'h00, 1'b0, 9'h100, 8'h00, 2'b00});
		ext_mode = 1'b1;
		repeat (3) @(negedge clock);
		chk("restore", st, {8'hA5, 1'b1, 9'h0C0, 8'hFF, 2'b10});
		wr(4'h2, 16'h0000);
		chk("zero", st, {8'h00, 1'b0, 9'h0C0, 8'hFF, 2'b11});
		$display("test mode done");
		// mid-run reset must restore the images and clear the sticky filler flag
		resetn = 1'b0;
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		@(negedge clock);
		chk("rerun", st, {8'h00, 1'b0, 9'h100, 8'h00, 2'b00});
		$display("test reset done");
		results();
	end
endmodule : testbench
`default_nettype wire
